// ### fis_pkg.sv
package fis_pkg;

  // ----------------------------------------
  // instruction cycle addresses and data
  // ----------------------------------------
  localparam logic [11:0] FIS_UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] FIS_UNLOCK2_ADDR = 12'hAAA;
  localparam logic [7:0] FIS_UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] FIS_UNLOCK2_DATA = 8'h55;

  // command bytes, kept here so a variant can recode them
  localparam logic [7:0] FIS_CMD_PROG = 8'hA0;
  localparam logic [7:0] FIS_CMD_ERASE = 8'h80;
  localparam logic [7:0] FIS_CMD_SECT = 8'h30;
  localparam logic [7:0] FIS_CMD_BULK = 8'h10;
  localparam logic [7:0] FIS_CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] FIS_CMD_RESUME = 8'h30;
  localparam logic [7:0] FIS_CMD_RESET = 8'hF0;
  localparam logic [7:0] FIS_CMD_INFO = 8'h90;
  localparam logic [7:0] FIS_CMD_BYPASS = 8'h20;
  localparam logic [7:0] FIS_CMD_BYP_EXIT = 8'h00;

  // ----------------------------------------
  // information reads
  // ----------------------------------------
  localparam logic [1:0] FIS_ID_OFS = 2'h1;
  localparam logic [1:0] FIS_PROT_OFS = 2'h2;
  localparam logic [7:0] FIS_ID_CODE = 8'h5A; // arbitrary value
  localparam int FIS_ST_DONE_BIT = 7;
  localparam int FIS_ST_TOGGLE_BIT = 6;
  localparam int FIS_ST_ERR_BIT = 5;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int FIS_CLK_NS = 100;
  localparam int FIS_COLLECT_US = 80;
  localparam int FIS_COLLECT_CYC = (FIS_COLLECT_US * 1000) / FIS_CLK_NS;
  localparam int FIS_TIMEOUT_DEF = 1000;
  localparam logic [15:0] FIS_PROG_CYC = 16'h0010;
  localparam logic [15:0] FIS_ERASE_CYC = 16'h0040;
  localparam logic [15:0] FIS_CNT_RESET = 16'h0000;

endpackage : fis_pkg

// ### fis_op_if.sv
`timescale 1ns/1ps
interface fis_op_if;
  logic start;
  logic is_erase;
  logic bank;
  logic [7:0] sect_mask;
  logic [15:0] addr;
  logic [7:0] data;
  logic suspend;
  logic resume;
  logic busy;
  logic suspended;

  modport ctl (output start, is_erase, bank, sect_mask, addr, data, suspend, resume,
               input busy, suspended);
  modport eng (input start, is_erase, bank, sect_mask, addr, data, suspend, resume,
               output busy, suspended);
endinterface : fis_op_if

// ### fis_engine.sv
`timescale 1ns/1ps
module fis_engine
  import fis_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  fis_op_if.eng op,
  output logic arr_prog_o,
  output logic arr_erase_o,
  output logic arr_bank_o,
  output logic [15:0] arr_addr_o,
  output logic [7:0] arr_data_o,
  output logic [7:0] arr_sect_o
);

  typedef enum {EN_IDLE, EN_RUN, EN_SUSP} fis_eng_state_t;

  fis_eng_state_t state_reg;
  logic erase_reg;
  logic [15:0] cnt_reg;
  wire finish = (state_reg == EN_RUN) && (cnt_reg == 16'h0001);

  // ----------------------------------------
  // embedded algorithm timer
  // ----------------------------------------
  // only an erase may be parked; a program is too short to bother
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= EN_IDLE;
      erase_reg <= 1'b0;
      cnt_reg <= FIS_CNT_RESET;
    end else begin
      case (state_reg)
        EN_IDLE: if (op.start) begin
          state_reg <= EN_RUN;
          erase_reg <= op.is_erase;
          cnt_reg <= op.is_erase ? FIS_ERASE_CYC : FIS_PROG_CYC;
        end
        EN_RUN: if (op.suspend && erase_reg) begin
          state_reg <= EN_SUSP;
        end else if (finish) begin
          state_reg <= EN_IDLE;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
        EN_SUSP: if (op.resume) begin
          state_reg <= EN_RUN;
        end
        default: state_reg <= EN_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // array strobes, one cycle each
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arr_prog_o <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_bank_o <= 1'b0;
      arr_addr_o <= 16'h0000;
      arr_data_o <= 8'h00;
      arr_sect_o <= 8'h00;
    end else begin
      arr_prog_o <= finish && !erase_reg;
      arr_erase_o <= finish && erase_reg;
      if (op.start && state_reg == EN_IDLE) begin
        arr_bank_o <= op.bank;
        arr_addr_o <= op.addr;
        arr_data_o <= op.data;
        arr_sect_o <= op.sect_mask;
      end
    end
  end

  assign op.busy = (state_reg == EN_RUN);
  assign op.suspended = (state_reg == EN_SUSP);

  susp_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == EN_SUSP) |=> $stable(cnt_reg))
    else $error("erase counter moved while suspended");

endmodule : fis_engine

// ### flash_instruction_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - main flash has eight sectors, each with its own select
// - secondary flash has four 8 KB sectors, each with its own select
// - every sector may be protected; program or erase there is refused
// - erase works per sector, programming per byte
// - sector erase can be suspended, other sectors read, then resumed
// - ready/busy pin low during program, erase or sector collection, high otherwise
// - each sector select is the OR of up to three decoded terms
// - reads in read-array mode return array data like a ROM
// - plain host writes never change the array
// - writes to a selected flash go to the sequence decoder
// - execute only after all bytes, each gap under the timeout
// - invalid byte or gap timeout drops back to read-array mode; an invalid byte in bypass stays in bypass
// - instructions open with AAh at X555h then 55h at XAAAh
// - upper address ignored; host keeps the sector select active
// - any main select routes to main flash, secondary to secondary
// - both arrays share commands; identifier read is main flash only
// - erase, suspend, resume, program, reset, id, protection, bypass
// - some instructions end in reads returning non-array information
// - only address bits 11 to 0 are matched in instruction cycles
// - further sector confirms within 80 us, then collection closes
// - protection read gives 00h unprotected, 01h protected
// - after id, protection read or error, stay until reset command
module flash_instruction_sequencer
  import fis_pkg::*;
#(
  parameter int TIMEOUT_CYC = FIS_TIMEOUT_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [23:0] main_sel_terms_i,
  input wire logic [11:0] sec_sel_terms_i,
  input wire logic [7:0] main_protect_i,
  input wire logic [3:0] sec_protect_i,
  input wire logic [7:0] arr_rdata_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rvalid_o,
  output logic ready_busy_pin_o,
  output logic error_flag_bit_o,
  output logic arr_prog_o,
  output logic arr_erase_o,
  output logic arr_bank_o,
  output logic [15:0] arr_addr_o,
  output logic [7:0] arr_data_o,
  output logic [7:0] arr_sect_o
);

  typedef enum {
    ST_READ, ST_UNL1, ST_UNL2, ST_PROG, ST_ERA1, ST_ERA2, ST_ERA3,
    ST_COLLECT, ST_INFO, ST_ERROR, ST_BYPASS, ST_BYP_PROG, ST_BYP_EXIT
  } fis_state_t;

  localparam int TMO_LAST = TIMEOUT_CYC - 1;
  localparam int COL_LAST = FIS_COLLECT_CYC - 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one instruction cycle match on the low address and the data byte
  function automatic logic cyc_match(input logic [11:0] a, input logic [7:0] d,
                                     input logic [11:0] ea, input logic [7:0] ed);
    cyc_match = (a == ea) && (d == ed);
  endfunction : cyc_match

  fis_op_if op_bus ();

  fis_state_t state_reg, state_next;
  logic bank_reg, bank_next;
  logic [7:0] mask_reg, mask_next;
  logic [15:0] cnt_reg, cnt_next;
  logic err_reg, err_next;
  logic toggle_reg;

  // ----------------------------------------
  // sector selects
  // ----------------------------------------
  // each select is an OR of three terms so a sector can sit at several ranges
  logic [7:0] main_sector_select;
  logic [3:0] secondary_sector_select;
  for (genvar i = 0; i < 8; i++) begin : g_main_sel
    assign main_sector_select[i] = |main_sel_terms_i[3*i +: 3];
  end
  for (genvar j = 0; j < 4; j++) begin : g_sec_sel
    assign secondary_sector_select[j] = |sec_sel_terms_i[3*j +: 3];
  end

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  // main wins if the decode logic ever selects both arrays at once
  wire main_any = |main_sector_select;
  wire sec_any = |secondary_sector_select;
  wire cur_bank = !main_any;
  wire flash_sel = main_any || sec_any;
  wire wr_hit = bus_wr_i && flash_sel;
  wire rd_hit = bus_rd_i && flash_sel;
  wire [11:0] low_addr = bus_addr_i[11:0];
  wire [7:0] wd = bus_wdata_i;
  wire same_bank = (cur_bank == bank_reg);
  wire [7:0] cur_sel = cur_bank ? {4'h0, secondary_sector_select} : main_sector_select;
  wire [7:0] cur_pmask = cur_bank ? {4'h0, sec_protect_i} : main_protect_i;
  wire [7:0] bank_pmask = bank_reg ? {4'hF, sec_protect_i} : main_protect_i;
  wire cur_prot = |(cur_sel & cur_pmask);
  wire is_un1 = cyc_match(low_addr, wd, FIS_UNLOCK1_ADDR, FIS_UNLOCK1_DATA);
  wire is_un2 = cyc_match(low_addr, wd, FIS_UNLOCK2_ADDR, FIS_UNLOCK2_DATA);
  wire at_555 = (low_addr == FIS_UNLOCK1_ADDR);
  wire is_rst = (wd == FIS_CMD_RESET);
  wire eng_run = op_bus.busy;
  wire eng_susp = op_bus.suspended;
  wire pending = (state_reg == ST_UNL1) || (state_reg == ST_UNL2) ||
                 (state_reg == ST_PROG) || (state_reg == ST_ERA1) ||
                 (state_reg == ST_ERA2) || (state_reg == ST_ERA3) ||
                 (state_reg == ST_BYP_PROG) || (state_reg == ST_BYP_EXIT);
  wire tmo_hit = pending && !wr_hit && (cnt_reg == 16'(TMO_LAST));
  wire col_end = (state_reg == ST_COLLECT) && !wr_hit && (cnt_reg == 16'(COL_LAST));

  // ----------------------------------------
  // sequence decoder
  // ----------------------------------------
  // an unexpected byte lands in read-array mode, except in the bypass, information and error states,
  // which stay put or return to bypass, so a stray write can never reach the array
  always_comb begin
    state_next = state_reg;
    bank_next = bank_reg;
    mask_next = mask_reg;
    err_next = err_reg;
    cnt_next = wr_hit ? FIS_CNT_RESET : cnt_reg + 16'h0001;
    op_bus.start = 1'b0;
    op_bus.is_erase = 1'b0;
    op_bus.bank = bank_reg;
    op_bus.sect_mask = cur_sel;
    op_bus.addr = bus_addr_i;
    op_bus.data = wd;
    op_bus.suspend = 1'b0;
    op_bus.resume = 1'b0;
    if (eng_run) begin
      // while the algorithm runs only a suspend is heard
      op_bus.suspend = wr_hit && (wd == FIS_CMD_SUSPEND);
    end else if (tmo_hit) begin
      state_next = ST_READ;
    end else if (col_end) begin
      // window closed: start on what was gathered
      state_next = ST_READ;
      op_bus.start = (mask_reg != 8'h00);
      op_bus.is_erase = 1'b1;
      op_bus.sect_mask = mask_reg;
      if (mask_reg == 8'h00) begin
        state_next = ST_ERROR;
        err_next = 1'b1;
      end
    end else if (wr_hit) begin
      case (state_reg)
        ST_READ: begin
          if (eng_susp && wd == FIS_CMD_RESUME) begin
            op_bus.resume = 1'b1;
          end else if (is_un1) begin
            state_next = ST_UNL1;
            bank_next = cur_bank;
          end
        end
        ST_UNL1: state_next = (is_un2 && same_bank) ? ST_UNL2 : ST_READ;
        ST_UNL2: begin
          state_next = ST_READ;
          if (same_bank && at_555) begin
            case (wd)
              FIS_CMD_PROG: state_next = ST_PROG;
              FIS_CMD_ERASE: state_next = eng_susp ? ST_READ : ST_ERA1;
              FIS_CMD_INFO: state_next = bank_reg ? ST_READ : ST_INFO;
              FIS_CMD_BYPASS: state_next = eng_susp ? ST_READ : ST_BYPASS;
              default: state_next = ST_READ;
            endcase
          end
        end
        ST_PROG, ST_BYP_PROG: begin
          // the data byte; a protected target sets the error flag instead
          state_next = (state_reg == ST_BYP_PROG) ? ST_BYPASS : ST_READ;
          if (!same_bank || eng_susp) begin
            state_next = ST_READ;
          end else if (cur_prot) begin
            state_next = ST_ERROR;
            err_next = 1'b1;
          end else begin
            op_bus.start = 1'b1;
          end
        end
        ST_ERA1: state_next = (is_un1 && same_bank) ? ST_ERA2 : ST_READ;
        ST_ERA2: state_next = (is_un2 && same_bank) ? ST_ERA3 : ST_READ;
        ST_ERA3: begin
          state_next = ST_READ;
          if (same_bank && wd == FIS_CMD_SECT) begin
            state_next = ST_COLLECT;
            mask_next = cur_sel & ~cur_pmask;
          end else if (same_bank && at_555 && wd == FIS_CMD_BULK) begin
            // whole array: every unprotected sector of the bank
            state_next = ST_READ;
            op_bus.start = ~bank_pmask != 8'h00;
            op_bus.is_erase = 1'b1;
            op_bus.sect_mask = ~bank_pmask;
            if (bank_pmask == 8'hFF) begin
              state_next = ST_ERROR;
              err_next = 1'b1;
            end
          end
        end
        ST_COLLECT: begin
          if (same_bank && wd == FIS_CMD_SECT) begin
            mask_next = mask_reg | (cur_sel & ~cur_pmask);
          end else begin
            state_next = ST_READ;
          end
        end
        ST_INFO, ST_ERROR: begin
          if (is_rst) begin
            state_next = ST_READ;
            err_next = 1'b0;
          end
        end
        ST_BYPASS: begin
          if (wd == FIS_CMD_PROG) begin
            state_next = ST_BYP_PROG;
          end else if (wd == FIS_CMD_INFO) begin
            state_next = ST_BYP_EXIT;
          end
        end
        ST_BYP_EXIT: state_next = (wd == FIS_CMD_BYP_EXIT) ? ST_READ : ST_BYPASS;
        default: state_next = ST_READ;
      endcase
    end
  end

  // ----------------------------------------
  // decoder state
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_READ;
      bank_reg <= 1'b0;
      mask_reg <= 8'h00;
      cnt_reg <= FIS_CNT_RESET;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bank_reg <= bank_next;
      mask_reg <= mask_next;
      cnt_reg <= cnt_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // status shows while busy so the host can poll, with a toggling bit
  wire show_status = eng_run || (state_reg == ST_COLLECT) || (state_reg == ST_ERROR);
  wire [7:0] status_byte = {!eng_run, toggle_reg, err_reg, 5'h00};
  wire [7:0] info_byte = (bus_addr_i[1:0] == FIS_ID_OFS) ? FIS_ID_CODE :
                         (bus_addr_i[1:0] == FIS_PROT_OFS) ? {7'h00, cur_prot} : 8'h00;
  wire [7:0] rd_sel = show_status ? status_byte :
                      (state_reg == ST_INFO) ? info_byte : arr_rdata_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rdata_o <= 8'h00;
      bus_rvalid_o <= 1'b0;
      toggle_reg <= 1'b0;
    end else begin
      bus_rvalid_o <= rd_hit;
      if (rd_hit) begin
        bus_rdata_o <= rd_sel;
        toggle_reg <= toggle_reg ^ show_status;
      end
    end
  end

  // ----------------------------------------
  // pins and engine
  // ----------------------------------------
  // sector collection counts as busy, though a write other than a sector confirm still drops the erase
  assign ready_busy_pin_o = !(eng_run || (state_reg == ST_COLLECT));
  assign error_flag_bit_o = err_reg;

  fis_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .op(op_bus),
    .arr_prog_o(arr_prog_o),
    .arr_erase_o(arr_erase_o),
    .arr_bank_o(arr_bank_o),
    .arr_addr_o(arr_addr_o),
    .arr_data_o(arr_data_o),
    .arr_sect_o(arr_sect_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_unlock;
    (state_reg == ST_READ) && wr_hit && is_un1 && !eng_run && !eng_susp;
  endsequence

  unlock_entry_a: assert property (s_unlock |=> state_reg == ST_UNL1)
    else $error("first unlock cycle not taken");

  bank_route_a: assert property (s_unlock |=> bank_reg == $past(cur_bank))
    else $error("instruction routed to wrong array");

  prot_refuse_a: assert property (op_bus.start |->
    (op_bus.sect_mask & (op_bus.is_erase ? bank_pmask : cur_pmask)) == 8'h00)
    else $error("operation started on a protected sector");

  plain_write_a: assert property ((state_reg == ST_READ) && wr_hit |-> !op_bus.start)
    else $error("plain write started an array operation");

  gap_timeout_a: assert property (tmo_hit && !eng_run |=> state_reg == ST_READ)
    else $error("inter-byte timeout did not abort");

  collect_close_a: assert property (col_end && !eng_run |=> state_reg != ST_COLLECT)
    else $error("sector collection outlived its window");

  busy_pin_a: assert property (op_bus.start |=> !ready_busy_pin_o [*2])
    else $error("ready/busy not low after start");

  id_main_only_a: assert property (state_reg == ST_INFO |-> !bank_reg)
    else $error("identifier mode entered on secondary flash");

  info_hold_a: assert property ((state_reg == ST_INFO) && !(wr_hit && is_rst)
    |=> state_reg == ST_INFO)
    else $error("information mode left without reset");

  prot_read_a: assert property (rd_hit && (state_reg == ST_INFO) && !eng_run
    && (bus_addr_i[1:0] == FIS_PROT_OFS) |=> bus_rdata_o == {7'h00, $past(cur_prot)})
    else $error("protection status byte wrong");

  rom_read_a: assert property (rd_hit && (state_reg == ST_READ) && !eng_run
    |=> bus_rvalid_o && bus_rdata_o == $past(arr_rdata_i))
    else $error("read-array data not returned");

endmodule : flash_instruction_sequencer

// ### fis_array_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// flash array behind the sequencer
// ----------------------------------------
module fis_array_model (
  input wire logic clk_i,
  input wire logic arr_prog_i,
  input wire logic arr_erase_i,
  input wire logic arr_bank_i,
  input wire logic [15:0] arr_addr_i,
  input wire logic [7:0] arr_data_i,
  input wire logic [7:0] arr_sect_i,
  input wire logic rd_bank_i,
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] arr_rdata_o
);
  // 256 bytes a bank; address bits 7:5 name the sector
  logic [7:0] mem_reg [2][256];

  initial begin
    foreach (mem_reg[b, i]) mem_reg[b][i] = 8'hFF;
  end

  // program only clears bits, as real cells do; erase sets the chosen sectors back to FFh
  always @(posedge clk_i) begin
    if (arr_prog_i) begin
      mem_reg[arr_bank_i][arr_addr_i[7:0]] <= mem_reg[arr_bank_i][arr_addr_i[7:0]] & arr_data_i;
    end
    if (arr_erase_i) begin
      for (int i = 0; i < 256; i++) begin
        if (arr_sect_i[i / 32]) mem_reg[arr_bank_i][i] <= 8'hFF;
      end
    end
  end

  assign arr_rdata_o = mem_reg[rd_bank_i][rd_addr_i[7:0]];
endmodule : fis_array_model

// ### test_flash_instruction_sequencer.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module test_flash_instruction_sequencer;
  import fis_pkg::*;
  localparam int TMO = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [23:0] mterm = 24'h000000;
  logic [11:0] sterm = 12'h000;
  logic [7:0] mprot = 8'h00;
  logic [3:0] sprot = 4'h0;
  logic [7:0] adata, rdata, pdata, sect_seen, exp_v, adat, asect;
  logic rvalid, rdy, errf, aprog, aerase, abank, bank_seen, rbank;
  logic [15:0] aaddr;
  int err_total = 0;
  int check_count = 0;
  int prog_n = 0;
  int erase_n = 0;
  int seed = 20;
  logic [7:0] expq[$];

  always #50 clk = ~clk;
  assign rbank = (|sterm) & ~(|mterm);

  flash_instruction_sequencer #(.TIMEOUT_CYC(TMO)) flash_instruction_sequencer_inst (
    .clk_i(clk), .rst_i(rst), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr),
    .bus_rd_i(rd), .main_sel_terms_i(mterm), .sec_sel_terms_i(sterm),
    .main_protect_i(mprot), .sec_protect_i(sprot), .arr_rdata_i(adata),
    .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .ready_busy_pin_o(rdy),
    .error_flag_bit_o(errf), .arr_prog_o(aprog), .arr_erase_o(aerase), .arr_bank_o(abank),
    .arr_addr_o(aaddr), .arr_data_o(adat), .arr_sect_o(asect));

  fis_array_model fis_array_model_inst (
    .clk_i(clk), .arr_prog_i(aprog), .arr_erase_i(aerase), .arr_bank_i(abank),
    .arr_addr_i(aaddr), .arr_data_i(adat), .arr_sect_i(asect), .rd_bank_i(rbank),
    .rd_addr_i(addr), .arr_rdata_o(adata));

  // ----------------------------------------
  // result side: oldest note against each read answer
  // ----------------------------------------
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        err_total++;
        $display("BAD %0t read answer with no note", $time);
      end else begin
        exp_v = expq.pop_front();
        `CHK(rdata, exp_v)
      end
    end
    if (aprog === 1'b1) begin
      prog_n++;
      bank_seen = abank;
    end
    if (aerase === 1'b1) begin
      erase_n++;
      sect_seen = asect;
    end
  end

  // ----------------------------------------
  // host side tasks, strobes change 5 ns after the edge
  // ----------------------------------------
  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #5 wr = 1'b0;
    @(posedge clk);
    #5;
  endtask : wr_b

  task automatic rd_b(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #5 rd = 1'b0;
    @(posedge clk);
    #5;
  endtask : rd_b

  // one of the three decoded terms picked at random
  task automatic sel(input logic bank, input int s);
    int t;
    t = {$random(seed)} % 3;
    mterm = 24'h000000;
    sterm = 12'h000;
    if (bank) sterm[3 * s + t] = 1'b1;
    else mterm[3 * s + t] = 1'b1;
  endtask : sel

  // upper address nibble set on purpose, it must not matter
  task automatic unlock;
    wr_b(16'hF555, FIS_UNLOCK1_DATA);
    wr_b(16'h3AAA, FIS_UNLOCK2_DATA);
  endtask : unlock

  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin
      @(posedge clk);
      #5;
      n++;
    end
    `CHK(rdy, 1'b1)
    @(posedge clk);
    #5;
  endtask : wait_rdy

  task automatic prog(input logic b, input int s, input logic [15:0] a, input logic [7:0] d);
    sel(b, s);
    unlock();
    wr_b(16'h8555, FIS_CMD_PROG);
    wr_b(a, d);
    // a protected target starts nothing, so the pin stays ready
    `CHK(rdy, b ? sprot[s] : mprot[s])
    wait_rdy(40);
  endtask : prog

  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note

  task automatic close_out;
    // let the last read answer reach the result side first
    repeat (3) @(posedge clk);
    if (expq.size() != 0) begin
      err_total++;
      $display("BAD %0t read answer never came", $time);
    end
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // whole run is under 1500 cycles, the 30000-cycle limit allows at least twenty times more
  initial begin
    #3000000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    #5 rst = 1'b0;
    `CHK(rdy, 1'b1)
    `CHK(errf, 1'b0)
    sel(0, 0);
    wr_b(16'h0010, 8'h12);
    rd_b(16'h0010, 8'hFF);
    note("plain access");
    pdata = $random(seed);
    prog(0, 2, 16'h8045, pdata);
    rd_b(16'h0045, pdata);
    prog(1, 3, 16'h0065, 8'h3C);
    `CHK(bank_seen, 1'b1)
    rd_b(16'h0065, 8'h3C);
    note("program");
    sel(0, 0);
    wr_b(16'h0555, FIS_UNLOCK1_DATA);
    wr_b(16'h0AAA, 8'h56);
    wr_b(16'h0555, FIS_CMD_PROG);
    wr_b(16'h0011, 8'h00);
    unlock();
    repeat (TMO + 5) @(posedge clk);
    #5;
    wr_b(16'h0555, FIS_CMD_PROG);
    wr_b(16'h0012, 8'h00);
    `CHK(rdy, 1'b1)
    `CHK(prog_n, 2)
    rd_b(16'h0012, 8'hFF);
    note("abort");
    mprot = 8'h02;
    prog(0, 1, 16'h0025, 8'h00);
    `CHK(errf, 1'b1)
    unlock();
    wr_b(16'h0555, FIS_CMD_PROG);
    wr_b(16'h0026, 8'h00);
    `CHK(errf, 1'b1)
    `CHK(prog_n, 2)
    wr_b(16'h0000, FIS_CMD_RESET);
    `CHK(errf, 1'b0)
    note("protect");
    unlock();
    wr_b(16'h0555, FIS_CMD_INFO);
    rd_b(16'h0001, FIS_ID_CODE);
    rd_b(16'h0002, 8'h01);
    sel(0, 0);
    rd_b(16'h0002, 8'h00);
    rd_b(16'h0010, 8'h00);
    wr_b(16'h0000, FIS_CMD_RESET);
    rd_b(16'h0010, 8'hFF);
    sel(1, 0);
    unlock();
    wr_b(16'h0555, FIS_CMD_INFO);
    rd_b(16'h0001, 8'hFF);
    note("info");
    sel(0, 0);
    unlock();
    wr_b(16'h0555, FIS_CMD_BYPASS);
    wr_b(16'h0123, FIS_CMD_PROG);
    wr_b(16'h0003, 8'hC3);
    wait_rdy(40);
    `CHK(prog_n, 3)
    wr_b(16'h0000, FIS_CMD_INFO);
    wr_b(16'h0000, FIS_CMD_BYP_EXIT);
    rd_b(16'h0003, 8'hC3);
    note("bypass");
    sel(0, 2);
    unlock();
    wr_b(16'h0555, FIS_CMD_ERASE);
    unlock();
    wr_b(16'h0040, FIS_CMD_SECT);
    `CHK(rdy, 1'b0)
    sel(0, 3);
    wr_b(16'h0060, FIS_CMD_SECT);
    repeat (FIS_COLLECT_CYC + 8) @(posedge clk);
    #5;
    sel(0, 0);
    wr_b(16'h0000, FIS_CMD_SUSPEND);
    repeat (80) @(posedge clk);
    #5;
    `CHK(erase_n, 0)
    rd_b(16'h0003, 8'hC3);
    wr_b(16'h0000, FIS_CMD_RESUME);
    // status while the erase runs: done bit low, toggle bit flips per read
    rd_b(16'h0000, 8'h00);
    rd_b(16'h0000, 8'h40);
    wait_rdy(200);
    `CHK(erase_n, 1)
    `CHK(sect_seen, 8'h0C)
    sel(0, 2);
    rd_b(16'h0045, 8'hFF);
    note("erase");
    sel(1, 0);
    unlock();
    wr_b(16'h0555, FIS_CMD_ERASE);
    unlock();
    wr_b(16'h0555, FIS_CMD_BULK);
    `CHK(rdy, 1'b0)
    wait_rdy(200);
    `CHK(erase_n, 2)
    `CHK(sect_seen, 8'h0F)
    rd_b(16'h0065, 8'hFF);
    note("bulk erase");
    close_out();
  end
endmodule : test_flash_instruction_sequencer
